/* File: verilog/clp_pkg.sv */
// Shared constants for the clock-loss register and page-select block.
// Assumes a 10-bit word address bus and 16-bit data from the SPI slave logic.
package clp_pkg;

  // Register word addresses
  localparam logic [9:0] CLP_ADDR_CLOCK_LOSS = 10'h1c7;
  localparam logic [9:0] CLP_ADDR_PAGE_SEL = 10'h3ff;

  // Clock-loss register bit positions
  localparam int CLP_BIT_REF_LOST = 0;
  localparam int CLP_BIT_RETURN_EXT = 1;
  localparam int CLP_BIT_HOST_IRQ_EN = 2;
  localparam int CLP_BIT_CORE_EN_LO = 3;
  localparam int CLP_BIT_CORE_EN_HI = 6;
  localparam int CLP_BIT_GATE_DRV = 7;
  localparam int CLP_BIT_TIMING_FAULT = 8;

  // Reset values
  localparam logic [15:0] CLP_CLOCK_LOSS_RESET = 16'h0000;
  localparam logic [2:0] CLP_PAGE_RESET = 3'h0;

  // Page-select codes
  localparam logic [2:0] CLP_PAGE_NONE = 3'h0;
  localparam logic [2:0] CLP_PAGE_PROG1 = 3'h1;
  localparam logic [2:0] CLP_PAGE_PROG2 = 3'h2;
  localparam logic [2:0] CLP_PAGE_PROG_BOTH = 3'h3;
  localparam logic [2:0] CLP_PAGE_COMMON = 3'h4;
  localparam logic [2:0] CLP_PAGE_COMMON_ALIAS = 3'h5;
  localparam logic [2:0] CLP_PAGE_BAD_A = 3'h6;
  localparam logic [2:0] CLP_PAGE_BAD_B = 3'h7;

  // Common-page area bounds (inclusive low, exclusive high)
  localparam logic [9:0] CLP_DATA1_LO = 10'h000;
  localparam logic [9:0] CLP_DATA2_LO = 10'h080;
  localparam logic [9:0] CLP_CFG1_LO = 10'h100;
  localparam logic [9:0] CLP_CFG2_LO = 10'h120;
  localparam logic [9:0] CLP_IO_LO = 10'h140;
  localparam logic [9:0] CLP_DIAG_LO = 10'h180;
  localparam logic [9:0] CLP_MAIN_LO = 10'h1c0;
  localparam logic [9:0] CLP_MAIN_HI = 10'h200;

  // Decipher keystream seed; value is arbitrary
  localparam logic [15:0] CLP_CIPHER_SEED = 16'h5a3c;

  // Area select index within a channel group
  localparam int CLP_SEL_DATA = 0;
  localparam int CLP_SEL_PROG = 1;
  localparam int CLP_SEL_CFG = 2;

endpackage : clp_pkg

/* File: verilog/clp_code_decipher.sv */
// Decipher unit for program code written over SPI.
// Assumes one code word per strobe on sys_clk; restart strobe from page logic.
`timescale 1ns/1ps
module clp_code_decipher
  import clp_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter logic [15:0] SEED = CLP_CIPHER_SEED
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Cipher word in
  input wire logic restart,
  input wire logic wordValid,
  input wire logic [DATA_W-1:0] cipherWord,
  // Plain word out
  output logic [DATA_W-1:0] plainWord_r
);

  logic [15:0] keyState_r;

  // Elaboration check: the keystream is 16 bits wide
  if (DATA_W != 16) begin : gWidthCheck
    $error("clp_code_decipher supports 16-bit words only");
  end

  // Next keystream state, 16-bit Galois shift
  function automatic logic [15:0] keyStep(input logic [15:0] s);
    keyStep = {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
  endfunction : keyStep

  // Keystream restarts on page selection, advances per word
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      keyState_r <= SEED;
    end else if (restart) begin
      keyState_r <= SEED;
    end else if (wordValid) begin
      keyState_r <= keyStep(keyState_r);
    end
  end

  // Always-on decode, no bypass path
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      plainWord_r <= '0;
    end else begin
      plainWord_r <= cipherWord ^ keyState_r;
    end
  end

endmodule : clp_code_decipher

/* File: verilog/clp_clock_loss_page.sv */
// Clock-loss control/status register, page select and area decode.
// Assumes SPI slave logic on sys_clk gives one-cycle read/write strobes with
// a word address; clock manager status inputs are on sys_clk too.
`timescale 1ns/1ps
// Function
// - Nine-bit clock-loss register records switch to the backup reference.
// - Timing fault flag set by violation, cleared by writing one.
// - Reference-lost flag is read-only and latches on missing reference.
// - Return bit acts on rising edge, clears when manager returns external.
// - Return bit written with no loss clears at once, no effect.
// - Host interrupt on missing clock when enabled, held until register read.
// - Four enables route clock-missing interrupts to four microcores.
// - Gate bit withdraws driver permit while clock-absent is high.
// - Enabled interrupts stay asserted while clock-absent remains set.
// - Microcore interrupt delivered only once external clock is valid.
// - Interrupt triggers on switch to internal and on SPI return attempt.
// - Program code is always deciphered before storing, no bypass.
// - Decipher restarts on each page write selecting program memory.
// - Page 000 ignores all accesses except to page-select register.
// - Page 001 selects channel 1 program RAM, 010 channel 2.
// - Page 011 broadcasts writes to both program RAMs; no reads.
// - Page 100 is common page; writing 101 stores 100.
// - Writes of 110 and 111 to page select are ignored.
// - Page-select register always reachable at its fixed address.
// - Decode nine area selects from address and page value.
// - Any pending source drives active-low host interrupt pin low.
module clp_clock_loss_page
  import clp_pkg::*;
#(
  parameter int ADDR_W = 10,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // SPI register access
  input wire logic [ADDR_W-1:0] spiAddr,
  input wire logic spiWrEn,
  input wire logic spiRdEn,
  input wire logic [DATA_W-1:0] spiWrData,
  output logic [DATA_W-1:0] spiRdData_r,
  output logic spiRdValid_r,
  // Clock manager
  input wire logic cksysMissing,
  input wire logic timingViolation,
  input wire logic pllOnExternal,
  input wire logic extClockValid,
  output logic returnToExtReq_r,
  output logic cksysDrvEn_r,
  // Interrupts
  input wire logic otherIrqReq,
  output logic host_interrupt_low_b_r,
  output logic [3:0] coreClockFailIrq_r,
  // Area selects and write data
  output logic [2:0] first_channel_area_selects_r,
  output logic [2:0] second_channel_area_selects_r,
  output logic mainCfgSel_r,
  output logic ioCfgSel_r,
  output logic diagCfgSel_r,
  output logic areaWr_r,
  output logic areaRd_r,
  output logic [DATA_W-1:0] areaWrData_r,
  output logic [DATA_W-1:0] progWrData_r
);

  // Elaboration check: map and register layout assume a 10/16 bit bus
  if (ADDR_W != 10 || DATA_W != 16) begin : gBusCheck
    $error("clp_clock_loss_page needs 10/16 bit bus");
  end

  // Register state
  logic refLost_r, returnExt_r, hostIrqEn_r, gateDrv_r, timingFault_r;
  logic [3:0] coreIrqEn_r;
  logic [3:0] corePend_r;
  logic [2:0] page_r;
  logic hostPend_r, missingPrev_r;

  // Access decode
  logic hitPage, hitClock, wrPage, wrClock, rdClock, commonPage;
  logic returnRise, returnAttempt, missingRise, clkEvent;
  logic pageWrOk, cipherRestart;
  logic [2:0] pageNxt;
  logic [15:0] clockRegView;

  // Range test used by every common-page area select
  function automatic logic inRange(input logic [9:0] a, input logic [9:0] lo,
                                   input logic [9:0] hi);
    inRange = (a >= lo) && (a < hi);
  endfunction : inRange

  assign hitPage = (spiAddr == CLP_ADDR_PAGE_SEL);
  assign commonPage = (page_r == CLP_PAGE_COMMON);
  assign hitClock = commonPage && (spiAddr == CLP_ADDR_CLOCK_LOSS);
  assign wrPage = spiWrEn && hitPage;
  assign wrClock = spiWrEn && hitClock;
  assign rdClock = spiRdEn && hitClock;
  assign missingRise = cksysMissing && !missingPrev_r;
  assign returnRise = wrClock && spiWrData[CLP_BIT_RETURN_EXT] && !returnExt_r;
  assign returnAttempt = returnRise && refLost_r;
  assign clkEvent = missingRise || returnAttempt;

  // Page value after write: alias folding and refusal
  always_comb begin
    pageNxt = spiWrData[2:0];
    pageWrOk = 1'b1;
    case (spiWrData[2:0])
      CLP_PAGE_COMMON_ALIAS: pageNxt = CLP_PAGE_COMMON;
      CLP_PAGE_BAD_A, CLP_PAGE_BAD_B: pageWrOk = 1'b0;
      default: pageNxt = spiWrData[2:0];
    endcase
  end

  assign cipherRestart = wrPage && pageWrOk &&
    (pageNxt == CLP_PAGE_PROG1 || pageNxt == CLP_PAGE_PROG2 ||
     pageNxt == CLP_PAGE_PROG_BOTH);

  // Page-select register
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      page_r <= CLP_PAGE_RESET;
    end else if (wrPage && pageWrOk) begin
      page_r <= pageNxt;
    end
  end

  // Missing-edge history
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      missingPrev_r <= 1'b0;
    end else begin
      missingPrev_r <= cksysMissing;
    end
  end

  // Reference-lost flag: set wins over the clear
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      refLost_r <= 1'b0;
    end else if (cksysMissing) begin
      refLost_r <= 1'b1;
    end else if (returnExt_r && pllOnExternal) begin
      refLost_r <= 1'b0;
    end
  end

  // Return-to-external request bit
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      returnExt_r <= 1'b0;
    end else if (returnAttempt) begin
      returnExt_r <= 1'b1;
    end else if (returnExt_r && pllOnExternal) begin
      returnExt_r <= 1'b0;
    end
  end

  // Enables and gating control
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      hostIrqEn_r <= 1'b0;
      coreIrqEn_r <= 4'h0;
      gateDrv_r <= 1'b0;
    end else if (wrClock) begin
      hostIrqEn_r <= spiWrData[CLP_BIT_HOST_IRQ_EN];
      coreIrqEn_r <= spiWrData[CLP_BIT_CORE_EN_HI:CLP_BIT_CORE_EN_LO];
      gateDrv_r <= spiWrData[CLP_BIT_GATE_DRV];
    end
  end

  // Timing fault: write-one clear, new violation wins
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      timingFault_r <= 1'b0;
    end else if (timingViolation) begin
      timingFault_r <= 1'b1;
    end else if (wrClock && spiWrData[CLP_BIT_TIMING_FAULT]) begin
      timingFault_r <= 1'b0;
    end
  end

  // Host pending: held while missing, cleared by a read afterwards
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      hostPend_r <= 1'b0;
    end else if (hostIrqEn_r && (cksysMissing || clkEvent)) begin
      hostPend_r <= 1'b1;
    end else if (rdClock) begin
      hostPend_r <= 1'b0;
    end
  end

  // Core pending: caught on event, held while missing, taken on delivery
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      corePend_r <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (coreIrqEn_r[i] && (cksysMissing || clkEvent)) begin
          corePend_r[i] <= 1'b1;
        end else if (extClockValid) begin
          corePend_r[i] <= 1'b0;
        end
      end
    end
  end

  // Core interrupt lines wait for a valid external clock
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      coreClockFailIrq_r <= 4'h0;
    end else begin
      coreClockFailIrq_r <= coreIrqEn_r & (corePend_r | {4{cksysMissing}}) &
        {4{extClockValid}};
    end
  end

  // Host pin and driver permit and manager request
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      host_interrupt_low_b_r <= 1'b1;
      cksysDrvEn_r <= 1'b1;
      returnToExtReq_r <= 1'b0;
    end else begin
      host_interrupt_low_b_r <= !(hostPend_r || otherIrqReq);
      cksysDrvEn_r <= !(gateDrv_r && cksysMissing);
      returnToExtReq_r <= returnExt_r;
    end
  end

  // Read view of the clock-loss register, reserved bits zero
  always_comb begin
    clockRegView = CLP_CLOCK_LOSS_RESET;
    clockRegView[CLP_BIT_REF_LOST] = refLost_r;
    clockRegView[CLP_BIT_RETURN_EXT] = returnExt_r;
    clockRegView[CLP_BIT_HOST_IRQ_EN] = hostIrqEn_r;
    clockRegView[CLP_BIT_CORE_EN_HI:CLP_BIT_CORE_EN_LO] = coreIrqEn_r;
    clockRegView[CLP_BIT_GATE_DRV] = gateDrv_r;
    clockRegView[CLP_BIT_TIMING_FAULT] = timingFault_r;
  end

  // Read data port
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      spiRdData_r <= '0;
      spiRdValid_r <= 1'b0;
    end else begin
      spiRdValid_r <= spiRdEn && (hitPage || hitClock);
      if (spiRdEn && hitPage) begin
        spiRdData_r <= {13'h0000, page_r};
      end else if (rdClock) begin
        spiRdData_r <= clockRegView;
      end else begin
        spiRdData_r <= '0;
      end
    end
  end

  // Area decode from page and address
  logic [2:0] sel1;
  logic [2:0] sel2;
  logic selMain;
  logic selIo;
  logic selDiag;
  logic anyAcc;

  assign anyAcc = (spiWrEn || spiRdEn) && !hitPage;

  always_comb begin
    sel1 = 3'h0;
    sel2 = 3'h0;
    selMain = 1'b0;
    selIo = 1'b0;
    selDiag = 1'b0;
    case (page_r)
      CLP_PAGE_PROG1: sel1[CLP_SEL_PROG] = anyAcc;
      CLP_PAGE_PROG2: sel2[CLP_SEL_PROG] = anyAcc;
      CLP_PAGE_PROG_BOTH: begin
        sel1[CLP_SEL_PROG] = spiWrEn && !hitPage;
        sel2[CLP_SEL_PROG] = spiWrEn && !hitPage;
      end
      CLP_PAGE_COMMON: begin
        sel1[CLP_SEL_DATA] = anyAcc && inRange(spiAddr, CLP_DATA1_LO, CLP_DATA2_LO);
        sel2[CLP_SEL_DATA] = anyAcc && inRange(spiAddr, CLP_DATA2_LO, CLP_CFG1_LO);
        sel1[CLP_SEL_CFG] = anyAcc && inRange(spiAddr, CLP_CFG1_LO, CLP_CFG2_LO);
        sel2[CLP_SEL_CFG] = anyAcc && inRange(spiAddr, CLP_CFG2_LO, CLP_IO_LO);
        selIo = anyAcc && inRange(spiAddr, CLP_IO_LO, CLP_DIAG_LO);
        selDiag = anyAcc && inRange(spiAddr, CLP_DIAG_LO, CLP_MAIN_LO);
        selMain = anyAcc && inRange(spiAddr, CLP_MAIN_LO, CLP_MAIN_HI);
      end
      default: sel1 = 3'h0;
    endcase
  end

  // Registered selects, strobes and write data
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      first_channel_area_selects_r <= 3'h0;
      second_channel_area_selects_r <= 3'h0;
      mainCfgSel_r <= 1'b0;
      ioCfgSel_r <= 1'b0;
      diagCfgSel_r <= 1'b0;
      areaWr_r <= 1'b0;
      areaRd_r <= 1'b0;
      areaWrData_r <= '0;
    end else begin
      first_channel_area_selects_r <= sel1;
      second_channel_area_selects_r <= sel2;
      mainCfgSel_r <= selMain;
      ioCfgSel_r <= selIo;
      diagCfgSel_r <= selDiag;
      areaWr_r <= spiWrEn && !hitPage && (page_r != CLP_PAGE_NONE);
      areaRd_r <= spiRdEn && !hitPage && (page_r != CLP_PAGE_NONE) &&
        (page_r != CLP_PAGE_PROG_BOTH);
      areaWrData_r <= spiWrData;
    end
  end

  // Program writes pass through the decipher unit
  logic progWord;
  assign progWord = spiWrEn && !hitPage &&
    (page_r == CLP_PAGE_PROG1 || page_r == CLP_PAGE_PROG2 ||
     page_r == CLP_PAGE_PROG_BOTH);

  clp_code_decipher #(
    .DATA_W(DATA_W),
    .SEED(CLP_CIPHER_SEED)
  ) uDecipher (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .restart(cipherRestart),
    .wordValid(progWord),
    .cipherWord(spiWrData),
    .plainWord_r(progWrData_r)
  );

endmodule : clp_clock_loss_page

/* File: sim/clp_clock_loss_page_sva.sv */
// Port checker for the clock-loss register and page-select block.
// Assumes it is bound into clp_clock_loss_page on sys_clk.
`timescale 1ns/1ps
module clp_clock_loss_page_sva
  import clp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register access
  input wire logic [9:0] spiAddr,
  input wire logic spiWrEn,
  input wire logic spiRdEn,
  input wire logic spiRdValid_r,
  // Clock manager and interrupts
  input wire logic cksysMissing,
  input wire logic pllOnExternal,
  input wire logic extClockValid,
  input wire logic otherIrqReq,
  input wire logic returnToExtReq_r,
  input wire logic cksysDrvEn_r,
  input wire logic host_interrupt_low_b_r,
  input wire logic [3:0] coreClockFailIrq_r,
  // Area decode
  input wire logic [2:0] first_channel_area_selects_r,
  input wire logic [2:0] second_channel_area_selects_r,
  input wire logic areaWr_r,
  input wire logic areaRd_r
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // Read answers and area strobes need a cause
  rd_valid_cause_a: assert property (spiRdValid_r |-> $past(spiRdEn))
    else $error("read valid without a read");
  page_reg_answer_a: assert property (
    spiRdEn && spiAddr == CLP_ADDR_PAGE_SEL |=> spiRdValid_r)
    else $error("page register read not answered");
  area_wr_cause_a: assert property (areaWr_r |->
    $past(spiWrEn) && $past(spiAddr) != CLP_ADDR_PAGE_SEL)
    else $error("area write without a paged write");
  bcast_no_read_a: assert property (
    first_channel_area_selects_r[1] && second_channel_area_selects_r[1]
    |-> areaWr_r && !areaRd_r)
    else $error("broadcast select on a read");
  // Clock-loss outputs
  core_irq_cause_a: assert property ($rose(|coreClockFailIrq_r)
    |-> $past(extClockValid))
    else $error("core interrupt without valid clock pin");
  drv_gate_cause_a: assert property (!cksysDrvEn_r |-> $past(cksysMissing))
    else $error("driver permit withdrawn without missing clock");
  other_irq_pin_a: assert property (
    otherIrqReq |-> ##[1:3] !host_interrupt_low_b_r)
    else $error("host pin not low for pending source");
  return_clear_a: assert property (
    returnToExtReq_r && pllOnExternal |-> ##[1:2] !returnToExtReq_r)
    else $error("return request not cleared");

  // Main scenarios reached
  cover property (first_channel_area_selects_r[1] && second_channel_area_selects_r[1]);
  cover property ($fell(cksysDrvEn_r));
  cover property ($rose(|coreClockFailIrq_r));
endmodule : clp_clock_loss_page_sva

/* File: sim/clp_host_model.sv */
// Host model: issues one-word register accesses on sys_clk.
// Assumes the bench calls acc for each access, one at a time.
`timescale 1ns/1ps
module clp_host_model (
  // Clock
  input wire logic sys_clk,
  // Register access
  output logic [9:0] spiAddr,
  output logic spiWrEn,
  output logic spiRdEn,
  output logic [15:0] spiWrData
);
  // Idle bus at time zero
  initial begin
    spiAddr = 10'h000;
    spiWrEn = 1'b0;
    spiRdEn = 1'b0;
    spiWrData = 16'h0000;
  end

  // Strobe for one taking edge, then show inverted values so stale data never matches
  task automatic acc(input logic w, input logic [9:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    spiAddr <= a;
    spiWrData <= v;
    spiWrEn <= w;
    spiRdEn <= !w;
    @(posedge sys_clk);
    spiWrEn <= 1'b0;
    spiRdEn <= 1'b0;
    spiAddr <= ~a;
    spiWrData <= ~v;
    #1;
  endtask : acc
endmodule : clp_host_model

/* File: sim/clp_clock_loss_page_bench.sv */
// Self-checking bench for the clock-loss register and page select.
// Assumes the host model drives all register accesses on sys_clk.
`timescale 1ns/1ps
module clp_clock_loss_page_bench;
  import clp_pkg::*;
  logic sys_clk, rst_b, cksysMissing, timingViolation, pllOnExternal;
  logic extClockValid, otherIrqReq, spiWrEn, spiRdEn, spiRdValid_r;
  logic returnToExtReq_r, cksysDrvEn_r, host_interrupt_low_b_r;
  logic mainCfgSel_r, ioCfgSel_r, diagCfgSel_r, areaWr_r, areaRd_r;
  logic [9:0] spiAddr;
  logic [15:0] spiWrData, spiRdData_r, areaWrData_r, progWrData_r, d, key;
  logic [3:0] coreClockFailIrq_r;
  logic [2:0] first_channel_area_selects_r, second_channel_area_selects_r;
  logic [9:0] aTab [7];
  logic [8:0] sTab [7];
  integer n_mismatch = 0, n_checks = 0, seed = 38220, pg, i, k;

  // Design and host model
  clp_clock_loss_page i_clp_clock_loss_page (.*);
  clp_host_model i_clp_host_model (.*);

  // Compare one value and count it
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Keystream model: 16-bit Galois shift, tap word b400
  function automatic logic [15:0] kstep(input logic [15:0] s);
    kstep = (s >> 1) ^ (s[0] ? 16'hb400 : 16'h0000);
  endfunction : kstep

  // Register write and checked read
  task automatic wr(input logic [9:0] a, input logic [15:0] v);
    i_clp_host_model.acc(1'b1, a, v);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic v, input logic [15:0] e);
    i_clp_host_model.acc(1'b0, a, 16'h0000);
    chk("rdValid", {15'h0000, spiRdValid_r}, {15'h0000, v});
    if (v)
      chk("rdData", spiRdData_r, e);
  endtask : rd

  // Verdict and end of run
  task automatic test_done;
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  // Waits a number of edges then samples settled outputs
  task automatic edges(input integer n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : edges

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Main sequence
  initial begin
    rst_b = 1'b0;
    cksysMissing = 1'b0;
    timingViolation = 1'b0;
    pllOnExternal = 1'b1;
    extClockValid = 1'b1;
    otherIrqReq = 1'b0;
    aTab = '{10'h000, 10'h080, 10'h100, 10'h120, 10'h140, 10'h180, 10'h1c0};
    sTab = '{9'h001, 9'h008, 9'h004, 9'h020, 9'h080, 9'h100, 9'h040};
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(CLP_ADDR_PAGE_SEL, 1'b1, 16'h0000);
    rd(CLP_ADDR_CLOCK_LOSS, 1'b0, 16'h0000);
    wr(CLP_ADDR_CLOCK_LOSS, 16'h00fc);
    // Every page code, disallowed ones keep the old value
    pg = 0;
    for (i = 0; i < 8; i++) begin
      d = $random(seed);
      wr(CLP_ADDR_PAGE_SEL, {d[15:3], i[2:0]});
      if (i < 6)
        pg = (i == 5) ? 4 : i;
      rd(CLP_ADDR_PAGE_SEL, 1'b1, pg[15:0]);
    end
    rd(CLP_ADDR_CLOCK_LOSS, 1'b1, 16'h0000);
    wr(CLP_ADDR_CLOCK_LOSS, 16'h00fe);
    rd(CLP_ADDR_CLOCK_LOSS, 1'b1, 16'h00fc);
    @(posedge sys_clk);
    timingViolation <= 1'b1;
    @(posedge sys_clk);
    timingViolation <= 1'b0;
    rd(CLP_ADDR_CLOCK_LOSS, 1'b1, 16'h01fc);
    wr(CLP_ADDR_CLOCK_LOSS, 16'h01fc);
    rd(CLP_ADDR_CLOCK_LOSS, 1'b1, 16'h00fc);
    // Clock loss with the clock pin still invalid
    @(posedge sys_clk);
    cksysMissing <= 1'b1;
    pllOnExternal <= 1'b0;
    extClockValid <= 1'b0;
    edges(3);
    chk("hostIrq", host_interrupt_low_b_r, 1'b0);
    chk("drvEn", cksysDrvEn_r, 1'b0);
    chk("coreIrq", coreClockFailIrq_r, 4'h0);
    @(posedge sys_clk);
    extClockValid <= 1'b1;
    edges(2);
    chk("coreIrq", coreClockFailIrq_r, 4'hf);
    rd(CLP_ADDR_CLOCK_LOSS, 1'b1, 16'h00fd);
    chk("hostIrq", host_interrupt_low_b_r, 1'b0);
    @(posedge sys_clk);
    cksysMissing <= 1'b0;
    edges(2);
    chk("drvEn", cksysDrvEn_r, 1'b1);
    chk("hostIrq", host_interrupt_low_b_r, 1'b0);
    rd(CLP_ADDR_CLOCK_LOSS, 1'b1, 16'h00fd);
    edges(2);
    chk("hostIrq", host_interrupt_low_b_r, 1'b1);
    // Return to the external reference once the pin is valid
    wr(CLP_ADDR_CLOCK_LOSS, 16'h00fe);
    edges(1);
    chk("coreIrq", coreClockFailIrq_r, 4'hf);
    chk("hostIrq", host_interrupt_low_b_r, 1'b0);
    rd(CLP_ADDR_CLOCK_LOSS, 1'b1, 16'h00ff);
    chk("retReq", returnToExtReq_r, 1'b1);
    @(posedge sys_clk);
    pllOnExternal <= 1'b1;
    k = 0;
    while (returnToExtReq_r !== 1'b0 && k < 8) begin
      edges(1);
      k++;
    end
    if (k == 8) begin
      n_mismatch++;
      test_done();
    end
    rd(CLP_ADDR_CLOCK_LOSS, 1'b1, 16'h00fc);
    @(posedge sys_clk);
    otherIrqReq <= 1'b1;
    edges(3);
    chk("hostIrq", host_interrupt_low_b_r, 1'b0);
    @(posedge sys_clk);
    otherIrqReq <= 1'b0;
    edges(3);
    chk("hostIrq", host_interrupt_low_b_r, 1'b1);
    // Program pages, keystream restarts on each page write
    for (i = 1; i < 4; i++) begin
      wr(CLP_ADDR_PAGE_SEL, i[15:0]);
      key = CLP_CIPHER_SEED;
      for (k = 0; k < 2; k++) begin
        d = $random(seed);
        wr(10'h055, d);
        chk("sel1", first_channel_area_selects_r, {1'b0, i[0], 1'b0});
        chk("sel2", second_channel_area_selects_r, {1'b0, i[1], 1'b0});
        chk("areaWr", areaWr_r, 1'b1);
        chk("keyStream", progWrData_r ^ d, key);
        chk("cipherOn", {15'h0000, progWrData_r == d}, 16'h0000);
        key = kstep(key);
      end
    end
    rd(10'h055, 1'b0, 16'h0000);
    chk("areaRd", areaRd_r, 1'b0);
    // Common page area map
    wr(CLP_ADDR_PAGE_SEL, 16'h0004);
    for (i = 0; i < 7; i++) begin
      d = $random(seed);
      wr(aTab[i], d);
      chk("areaSel", {diagCfgSel_r, ioCfgSel_r, mainCfgSel_r,
        second_channel_area_selects_r, first_channel_area_selects_r}, sTab[i]);
      chk("areaData", areaWrData_r, d);
    end
    test_done();
  end
endmodule : clp_clock_loss_page_bench

bind clp_clock_loss_page clp_clock_loss_page_sva i_clp_clock_loss_page_sva (.*);
